// *** dsil_defs.svh ***
// Purpose: Shared constants for the serial DAC input logic
// Assumes: System clock 25 MHz; link clock sampled, not used as a clock
// Notes:   Counts are in link clock cycles unless marked otherwise
`ifndef DSIL_DEFS_SVH
`define DSIL_DEFS_SVH

`define DSIL_WORD_BITS     16
`define DSIL_CELL_CLKS     16
`define DSIL_MSB_SAMPLE    24
`define DSIL_BIT_SAMPLE    16
`define DSIL_START_LEVEL   1'b0
`define DSIL_STOP_LEVEL    1'b1
`define DSIL_SYS_MHZ       25
`define DSIL_LINK_HALF_NS  200
`define DSIL_LINK_DIV      ((`DSIL_LINK_HALF_NS * `DSIL_SYS_MHZ + 999) / 1000)

`endif

// *** dsil_pkg.sv ***
// Purpose: Types for the serial DAC input logic
// Assumes: Constants live in dsil_defs.svh
// Notes:   None
package dsil_pkg;
  typedef enum logic [1:0] {
    DSIL_IDLE,
    DSIL_RECV,
    DSIL_ERRP
  } dsil_rx_e;

  typedef enum logic [1:0] {
    DSIL_H_IDLE,
    DSIL_H_SEND,
    DSIL_H_LOAD
  } dsil_tx_e;
endpackage

// *** dsil_if.sv ***
// Purpose: Link between serial controller and DAC input logic
// Assumes: Fault flag is open drain, wired with pull-up here
// Notes:   Controller drives clock, data and load strobe
`timescale 1ns/1ps
interface dsil_if;
  logic link_clk;
  logic data_in;
  logic load_strobe;
  logic data_out;
  logic fault_o;
  logic fault_oe;
  logic fault_n;

  // Open drain resolves low only while driven
  assign fault_n = (fault_oe & ~fault_o) ? 1'b0 : 1'b1;

  modport dev (
    input  link_clk,
    input  data_in,
    input  load_strobe,
    output data_out,
    output fault_o,
    output fault_oe,
    input  fault_n
  );

  modport ctl (
    output link_clk,
    output data_in,
    output load_strobe,
    input  data_out,
    input  fault_n
  );
endinterface

// *** dsil_device.sv ***
// Purpose: DAC serial input logic, three-wire and asynchronous modes
// Assumes: Link pins sampled on clk_sys through three flip-flops
// Notes:   Link clock edges found by second/third stage agreement
// Summary of operation
// - Async word framed by start 0, stop 1
// - Cells 16 clocks, sample at middle
// - Start cell begins first clock after fall
// - Top bit at 24, next 40, +16
// - Sender holds data high between words
// - Valid stop bit loads DAC word
// - Bad stop gives one-clock output pulse
// - Framing error keeps DAC value unchanged
// - Load strobe high selects async mode
// - Three-wire shifts data, strobe loads DAC
// - Fast edges may corrupt register; avoided
// - Controller holds strobe low while shifting
// - Controller keeps clock low during strobe
// - Word 16 bits, top bit first
// - Fault flag active low open drain
// - Three-wire captures data on rising clock
// - Shifted-out bits drive serial output chain
`timescale 1ns/1ps
`include "dsil_defs.svh"
module dsil_device (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  dsil_if.dev              lnk,
  input  wire logic        near_limit,
  output logic [15:0]      dac_word,
  output logic             dac_update,
  output logic             async_mode
);
  logic [2:0] clk_s_r, dat_s_r, ld_s_r;
  logic [2:0] clk_s_nxt, dat_s_nxt, ld_s_nxt;
  logic       clk_v_r, dat_v_r, ld_v_r;
  logic       clk_v_nxt, dat_v_nxt, ld_v_nxt;

  always_comb begin
    clk_s_nxt = {clk_s_r[1:0], lnk.link_clk};
    dat_s_nxt = {dat_s_r[1:0], lnk.data_in};
    ld_s_nxt  = {ld_s_r[1:0], lnk.load_strobe};
    clk_v_nxt = (clk_s_r[1] == clk_s_r[2]) ? clk_s_r[2] : clk_v_r;
    dat_v_nxt = (dat_s_r[1] == dat_s_r[2]) ? dat_s_r[2] : dat_v_r;
    ld_v_nxt  = (ld_s_r[1] == ld_s_r[2]) ? ld_s_r[2] : ld_v_r;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      clk_s_r <= 3'h0;
      dat_s_r <= 3'h7;
      ld_s_r  <= 3'h0;
      clk_v_r <= 1'b0;
      dat_v_r <= 1'b1;
      ld_v_r  <= 1'b0;
    end else begin
      clk_s_r <= clk_s_nxt;
      dat_s_r <= dat_s_nxt;
      ld_s_r  <= ld_s_nxt;
      clk_v_r <= clk_v_nxt;
      dat_v_r <= dat_v_nxt;
      ld_v_r  <= ld_v_nxt;
    end
  end

  logic clk_rise;
  logic ld_rise;
  // Edge events on filtered levels
  assign clk_rise = clk_v_nxt & ~clk_v_r;
  assign ld_rise  = ld_v_nxt & ~ld_v_r;

  // Main datapath state
  dsil_pkg::dsil_rx_e st_r, st_nxt;
  logic [15:0] shift_r, shift_nxt;
  logic [15:0] word_r, word_nxt;
  logic [5:0]  cnt_r, cnt_nxt;
  logic [4:0]  bits_r, bits_nxt;
  logic        dout_r, dout_nxt;
  logic        upd_r, upd_nxt;
  logic        prev_dat_r, prev_dat_nxt;

  always_comb begin
    st_nxt       = st_r;
    shift_nxt    = shift_r;
    word_nxt     = word_r;
    cnt_nxt      = cnt_r;
    bits_nxt     = bits_r;
    dout_nxt     = dout_r;
    upd_nxt      = 1'b0;
    prev_dat_nxt = prev_dat_r;
    if (!ld_v_r) begin
      st_nxt = dsil_pkg::DSIL_IDLE;
      if (clk_rise) begin
        shift_nxt = {shift_r[14:0], dat_v_r};
        dout_nxt  = shift_r[15];
      end
      if (ld_rise) begin
        word_nxt = shift_r;
        upd_nxt  = 1'b1;
      end
    end else if (clk_rise) begin
      prev_dat_nxt = dat_v_r;
      case (st_r)
        dsil_pkg::DSIL_IDLE: begin
          dout_nxt = 1'b0;
          // fall seen, cell starts next clock
          if (prev_dat_r && dat_v_r == `DSIL_START_LEVEL) begin
            st_nxt   = dsil_pkg::DSIL_RECV;
            cnt_nxt  = 6'h01;
            bits_nxt = 5'h00;
          end
        end
        dsil_pkg::DSIL_RECV: begin
          cnt_nxt = cnt_r + 6'h01;
          // sample at 24 then every 16
          if ((bits_r == 5'h00 && cnt_r == 6'(`DSIL_MSB_SAMPLE)) ||
              (bits_r != 5'h00 && cnt_r == 6'(`DSIL_BIT_SAMPLE))) begin
            cnt_nxt  = 6'h01;
            bits_nxt = bits_r + 5'h01;
            if (bits_r < 5'(`DSIL_WORD_BITS)) begin
              shift_nxt = {shift_r[14:0], dat_v_r};
            end else begin
              st_nxt = dsil_pkg::DSIL_IDLE;
              if (dat_v_r == `DSIL_STOP_LEVEL) begin
                word_nxt = shift_r;
                upd_nxt  = 1'b1;
              end else begin
                dout_nxt = 1'b1;
                st_nxt   = dsil_pkg::DSIL_ERRP;
              end
            end
          end
        end
        dsil_pkg::DSIL_ERRP: begin
          dout_nxt = 1'b0;
          st_nxt   = dsil_pkg::DSIL_IDLE;
        end
        default: st_nxt = dsil_pkg::DSIL_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_r       <= dsil_pkg::DSIL_IDLE;
      shift_r    <= 16'h0000;
      word_r     <= 16'h0000;
      cnt_r      <= 6'h00;
      bits_r     <= 5'h00;
      dout_r     <= 1'b0;
      upd_r      <= 1'b0;
      prev_dat_r <= 1'b1;
    end else begin
      st_r       <= st_nxt;
      shift_r    <= shift_nxt;
      word_r     <= word_nxt;
      cnt_r      <= cnt_nxt;
      bits_r     <= bits_nxt;
      dout_r     <= dout_nxt;
      upd_r      <= upd_nxt;
      prev_dat_r <= prev_dat_nxt;
    end
  end

  // Fault flag register
  logic fault_r, fault_nxt;
  always_comb begin
    fault_nxt = near_limit;
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fault_r <= 1'b0;
    end else begin
      fault_r <= fault_nxt;
    end
  end

  // Outputs
  assign lnk.data_out = dout_r;
  // open drain pulls low on fault
  assign lnk.fault_o  = 1'b0;
  assign lnk.fault_oe = fault_r;
  assign dac_word     = word_r;
  assign dac_update   = upd_r;
  assign async_mode   = ld_v_r;
endmodule

// *** dsil_ctl.sv ***
// Purpose: Serial controller end driving the DAC input logic
// Assumes: Link clock made here by divider from clk_sys
// Notes:   Async mode when strap async_sel high
`timescale 1ns/1ps
`include "dsil_defs.svh"
module dsil_ctl (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  dsil_if.ctl              lnk,
  input  wire logic        async_sel,
  input  wire logic        req_valid,
  input  wire logic [15:0] req_word,
  output logic             req_ready,
  output logic             fault_seen,
  output logic             frame_err
);
  // Link clock divider
  logic [3:0] div_r, div_nxt;
  logic       lclk_r, lclk_nxt;
  logic       fall_en;
  always_comb begin
    div_nxt  = div_r + 4'h1;
    lclk_nxt = lclk_r;
    if (div_r == 4'(`DSIL_LINK_DIV - 1)) begin
      div_nxt  = 4'h0;
      lclk_nxt = ~lclk_r;
    end
  end
  assign fall_en = (div_r == 4'(`DSIL_LINK_DIV - 1)) & lclk_r;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      div_r  <= 4'h0;
      lclk_r <= 1'b0;
    end else begin
      div_r  <= div_nxt;
      lclk_r <= lclk_nxt;
    end
  end

  // Sender state, changes data on link clock falls
  dsil_pkg::dsil_tx_e st_r, st_nxt;
  logic [17:0] sh_r, sh_nxt;
  logic [9:0]  cnt_r, cnt_nxt;
  logic        din_r, din_nxt;
  logic        ld_r, ld_nxt;
  logic        err_r, err_nxt;
  logic        lko_r, lko_nxt;
  always_comb begin
    st_nxt  = st_r;
    sh_nxt  = sh_r;
    cnt_nxt = cnt_r;
    din_nxt = din_r;
    ld_nxt  = async_sel;
    err_nxt = 1'b0;
    if (fall_en) begin
      case (st_r)
        dsil_pkg::DSIL_H_IDLE: begin
          din_nxt = 1'b1;
          if (req_valid) begin
            st_nxt  = dsil_pkg::DSIL_H_SEND;
            cnt_nxt = 10'h000;
            sh_nxt  = {`DSIL_START_LEVEL, req_word, `DSIL_STOP_LEVEL};
          end
        end
        dsil_pkg::DSIL_H_SEND: begin
          cnt_nxt = cnt_r + 10'h001;
          if (async_sel) begin
            din_nxt = sh_r[17];
            if (cnt_r[3:0] == 4'hf) begin
              sh_nxt = {sh_r[16:0], 1'b1};
            end
            if (cnt_r == 10'(18 * `DSIL_CELL_CLKS - 1)) begin
              st_nxt = dsil_pkg::DSIL_H_IDLE;
            end
          end else begin
            ld_nxt  = 1'b0;
            din_nxt = sh_r[16];
            sh_nxt  = {sh_r[16:0], 1'b1};
            if (cnt_r == 10'(`DSIL_WORD_BITS)) begin
              st_nxt = dsil_pkg::DSIL_H_LOAD;
            end
          end
        end
        dsil_pkg::DSIL_H_LOAD: begin
          // strobe one link period, clock low
          ld_nxt = ~ld_r;
          if (ld_r) begin
            st_nxt = dsil_pkg::DSIL_H_IDLE;
          end
        end
        default: st_nxt = dsil_pkg::DSIL_H_IDLE;
      endcase
    end else if (!async_sel) begin
      // Strobe holds between link clock falls
      ld_nxt = (st_r == dsil_pkg::DSIL_H_LOAD) & ld_r;
    end
    err_nxt = async_sel & lnk.data_out;
    // Link clock registered, gated in three-wire mode outside shifting
    lko_nxt = (async_sel || (st_nxt == dsil_pkg::DSIL_H_SEND && cnt_nxt != 10'h000)) ? lclk_nxt : 1'b0;
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_r  <= dsil_pkg::DSIL_H_IDLE;
      sh_r  <= 18'h3_ffff;
      cnt_r <= 10'h000;
      din_r <= 1'b1;
      ld_r  <= 1'b0;
      err_r <= 1'b0;
      lko_r <= 1'b0;
    end else begin
      st_r  <= st_nxt;
      sh_r  <= sh_nxt;
      cnt_r <= cnt_nxt;
      din_r <= din_nxt;
      ld_r  <= ld_nxt;
      err_r <= err_nxt;
      lko_r <= lko_nxt;
    end
  end

  // Link pins straight from flip-flops
  assign lnk.link_clk    = lko_r;
  assign lnk.data_in     = din_r;
  assign lnk.load_strobe = ld_r;
  assign req_ready       = (st_r == dsil_pkg::DSIL_H_IDLE) & fall_en;
  assign fault_seen      = ~lnk.fault_n;
  assign frame_err       = err_r;
endmodule

// *** dsil_properties.sv ***
// Purpose: Link protocol properties between controller and device
// Assumes: Link half period 5 clk_sys; async strap holds strobe high from reset
// Notes:   A strobe high for long means async mode
`timescale 1ns/1ps
module dsil_properties (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic link_clk,
  input wire logic data_in,
  input wire logic load_strobe,
  input wire logic data_out,
  input wire logic fault_o,
  input wire logic fault_oe,
  input wire logic fault_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // Strobe high ever since reset marks the async strap
  logic rst_d_r;
  logic strap_r;
  always_ff @(posedge clk_sys) begin
    rst_d_r <= reset;
    if (reset) begin
      strap_r <= 1'b1;
    end else if (!load_strobe && !rst_d_r) begin
      strap_r <= 1'b0;
    end
  end

  // Start bit holds low
  property p_start_low;
    $fell(data_in) && load_strobe |-> !data_in [*8];
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit too short");

  // No error pulse on good frames
  property p_no_err;
    load_strobe && strap_r |-> !data_out;
  endproperty
  a_no_err: assert property (p_no_err) else $error("unexpected error pulse");

  // Strobe lasts a link period
  property p_strobe_width;
    $fell(load_strobe) |-> $past(load_strobe, 8);
  endproperty
  a_strobe_width: assert property (p_strobe_width) else $error("strobe too short");

  // Clock low while strobing
  property p_strobe_clk_low;
    load_strobe && !strap_r |-> !link_clk;
  endproperty
  a_strobe_clk_low: assert property (p_strobe_clk_low) else $error("clock high in strobe");

  // Strobe low while shifting
  property p_clk_strobe;
    $rose(link_clk) |-> !load_strobe || strap_r;
  endproperty
  a_clk_strobe: assert property (p_clk_strobe) else $error("strobe high in shift");

  // Data moves while clock low
  property p_din_change;
    $changed(data_in) |-> !link_clk;
  endproperty
  a_din_change: assert property (p_din_change) else $error("data moved on high clock");

  // Chain output moves after rise
  property p_dout_rise;
    $changed(data_out) |-> link_clk;
  endproperty
  a_dout_rise: assert property (p_dout_rise) else $error("data_out moved on low clock");

  // Fault pulls line low
  property p_fault;
    fault_oe |-> !fault_o && !fault_n;
  endproperty
  a_fault: assert property (p_fault) else $error("fault line not low");

  // Main scenarios reached
  c_async: cover property (load_strobe && $past(load_strobe, 12) && $rose(link_clk));
  c_load: cover property ($fell(load_strobe));
  c_fault: cover property (!fault_n);
endmodule

// *** tb_dac_serial_input_logic.sv ***
// Purpose: Self-checking bench, controller and device joined
// Assumes: Second device driven by bench link at 320 ns
// Notes:   Second link injects one framing error in three frames
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb_dac_serial_input_logic;
  typedef struct {logic mode; logic [15:0] word;} dsil_row_s;
  logic        clk_sys, reset, near_limit, async_sel, req_valid, req_ready, fault_seen, frame_err;
  logic        dac_update, async_mode, dac_update2, async_mode2;
  logic [15:0] req_word, dac_word, dac_word2;
  int          n_mismatch = 0, n_tests = 0, n_err_hi = 0, n_upd2 = 0, n_ferr = 0, e0, u0;
  dsil_row_s   rows [5] = '{'{0, 16'h8001}, '{0, 16'hFFFF}, '{1, 16'h8001}, '{1, 16'h7FFE}, '{0, 16'h5A3C}};
  logic [15:0] fw [3] = '{16'h8421, 16'h1234, 16'h7BDE};
  logic        fs [3] = '{1'b1, 1'b0, 1'b1};

  dsil_if lnk ();
  dsil_if lnk2 ();
  dsil_ctl i_dsil_ctl (.clk_sys(clk_sys), .reset(reset), .lnk(lnk.ctl), .async_sel(async_sel),
    .req_valid(req_valid), .req_word(req_word), .req_ready(req_ready), .fault_seen(fault_seen),
    .frame_err(frame_err));
  dsil_device i_dsil_device (.clk_sys(clk_sys), .reset(reset), .lnk(lnk.dev), .near_limit(near_limit),
    .dac_word(dac_word), .dac_update(dac_update), .async_mode(async_mode));
  dsil_device i_dsil_device_b (.clk_sys(clk_sys), .reset(reset), .lnk(lnk2.dev), .near_limit(1'b0),
    .dac_word(dac_word2), .dac_update(dac_update2), .async_mode(async_mode2));
  dsil_properties i_dsil_properties (.clk_sys(clk_sys), .reset(reset), .link_clk(lnk.link_clk),
    .data_in(lnk.data_in), .load_strobe(lnk.load_strobe), .data_out(lnk.data_out),
    .fault_o(lnk.fault_o), .fault_oe(lnk.fault_oe), .fault_n(lnk.fault_n));

  // System clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Error pulse and update counters
  always @(posedge clk_sys) begin
    if (lnk2.data_out === 1'b1) n_err_hi <= n_err_hi + 1;
    if (dac_update2 === 1'b1) n_upd2 <= n_upd2 + 1;
    if (frame_err === 1'b1) n_ferr <= n_ferr + 1;
  end

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic do_reset(input logic m);
    reset = 1'b1;
    async_sel = m;
    repeat (12) @(negedge clk_sys);
    reset = 1'b0;
    repeat (20) @(negedge clk_sys);
  endtask

  // Hold request until taken
  task automatic send(input logic [15:0] w);
    int k;
    req_word = w;
    req_valid = 1'b1;
    for (k = 0; k < 200 && req_ready !== 1'b1; k++) @(negedge clk_sys);
    if (k == 200) begin
      n_mismatch++;
      end_of_test();
    end
    @(negedge clk_sys);
    req_valid = 1'b0;
    for (k = 0; k < 6000 && dac_update !== 1'b1; k++) @(negedge clk_sys);
    if (k == 6000) begin
      n_mismatch++;
      end_of_test();
    end
  endtask

  // One link bit, data set while clock low
  task automatic lbit(input logic d);
    lnk2.link_clk = 1'b0;
    lnk2.data_in = d;
    repeat (4) @(negedge clk_sys);
    lnk2.link_clk = 1'b1;
    repeat (4) @(negedge clk_sys);
  endtask

  task automatic frame(input logic [15:0] w, input logic stop);
    repeat (4) lbit(1'b1);
    repeat (16) lbit(1'b0);
    for (int b = 15; b >= 0; b--) repeat (16) lbit(w[b]);
    repeat (16) lbit(stop);
    repeat (4) lbit(1'b1);
    lnk2.link_clk = 1'b0;
  endtask

  initial begin
    reset = 1'b1;
    near_limit = 1'b0;
    req_valid = 1'b0;
    req_word = 16'h0000;
    async_sel = 1'b0;
    lnk2.link_clk = 1'b0;
    lnk2.data_in = 1'b1;
    lnk2.load_strobe = 1'b1;
    for (int i = 0; i < 5; i++) begin
      if (i == 0 || rows[i].mode != rows[i-1].mode) do_reset(rows[i].mode);
      send(rows[i].word);
      `CHK("dac_word", rows[i].word, dac_word)
      repeat (20) @(negedge clk_sys);
      `CHK("async_mode", rows[i].mode, async_mode)
    end
    `CHK("frame_err", 0, n_ferr)
    near_limit = 1'b1;
    repeat (4) @(negedge clk_sys);
    `CHK("fault_seen", 1'b1, fault_seen)
    near_limit = 1'b0;
    repeat (4) @(negedge clk_sys);
    `CHK("fault_n", 1'b1, lnk.fault_n)
    `CHK("async_mode2", 1'b1, async_mode2)
    for (int i = 0; i < 3; i++) begin
      e0 = n_err_hi;
      u0 = n_upd2;
      frame(fw[i], fs[i]);
      `CHK("err pulse", fs[i] ? 0 : 8, n_err_hi - e0)
      `CHK("update cnt", fs[i] ? 1 : 0, n_upd2 - u0)
      `CHK("dac_word2", fs[i] ? fw[i] : fw[0], dac_word2)
    end
    end_of_test();
  end
endmodule
